// file: shared/ctad_defines.vh
// constants for the test and addressing decode core
//
// Summary of operation
// - test sets N,Z from A, X or memory, clears V, keeps H,I,C
// - index post-increment: address is H:X, then H:X increments
// - offset8 post-increment: address H:X plus unsigned byte, then H:X+1
// - index offset16: high then low offset byte added to H:X
// - index offset8: one offset byte after opcode added to H:X
// - stack offset8: SP plus one offset byte; opcode has a prebyte
// - stack offset16: high then low offset byte added to SP
// - extended: two address bytes, high first, give the address
// - direct branch: direct address byte then signed relative byte
// - direct to indexed move: read direct, write at H:X, then H:X+1
// - immediate to direct move: store immediate byte at direct address
`ifndef CTAD_DEFINES_VH
`define CTAD_DEFINES_VH
// register byte offsets
`define CTAD_REG_CTRL   8'h00
`define CTAD_REG_STATUS 8'h04
`define CTAD_REG_PC     8'h08
`define CTAD_REG_ACC    8'h0C
`define CTAD_REG_HX     8'h10
`define CTAD_REG_SP     8'h14
`define CTAD_REG_CCR    8'h18
`define CTAD_REG_COUNT  8'h1C
// reset values
`define CTAD_RST_SP     16'h00FF
`define CTAD_RST_CCR    8'h68
// flag bit positions
`define CTAD_CCR_V      7
`define CTAD_CCR_N      2
`define CTAD_CCR_Z      1
// opcodes
`define CTAD_OP_PRE     8'h9E
`define CTAD_OP_TST_DIR 8'h3D
`define CTAD_OP_TST_A   8'h4D
`define CTAD_OP_TST_X   8'h5D
`define CTAD_OP_TST_IX1 8'h6D
`define CTAD_OP_TST_IX  8'h7D
`define CTAD_OP_STA_EXT 8'hC7
`define CTAD_OP_STA_IX2 8'hD7
`define CTAD_OP_STA_IX1 8'hE7
`define CTAD_OP_STA_IX  8'hF7
`define CTAD_OP_CBQ_DIR 8'h31
`define CTAD_OP_CBQ_X1P 8'h61
`define CTAD_OP_CBQ_XP  8'h71
`define CTAD_OP_MOV_DXP 8'h5E
`define CTAD_OP_MOV_IMD 8'h6E
`define CTAD_OP_TSX     8'h95
`define CTAD_OP_TXS     8'h94
`define CTAD_OP_TXA     8'h9F
// addressing modes
`define CTAD_M_INH  4'h0
`define CTAD_M_DIR  4'h1
`define CTAD_M_EXT  4'h2
`define CTAD_M_IX   4'h3
`define CTAD_M_IX1  4'h4
`define CTAD_M_IX2  4'h5
`define CTAD_M_SP1  4'h6
`define CTAD_M_SP2  4'h7
`define CTAD_M_IXP  4'h8
`define CTAD_M_IX1P 4'h9
// actions
`define CTAD_A_ILL   4'h0
`define CTAD_A_TSTM  4'h1
`define CTAD_A_TSTA  4'h2
`define CTAD_A_TSTX  4'h3
`define CTAD_A_STA   4'h4
`define CTAD_A_CBEQ  4'h5
`define CTAD_A_MOVDX 4'h6
`define CTAD_A_MOVID 4'h7
`define CTAD_A_TSX   4'h8
`define CTAD_A_TXS   4'h9
`define CTAD_A_TXA   4'hA
`endif

// file: src/ctad_agen.v
// effective address former for the memory operand modes
`timescale 1ns/1ps
`include "ctad_defines.vh"
module ctad_agen (
  // operand source
  input  wire [3:0]  mode,
  input  wire [7:0]  byte1,
  input  wire [7:0]  byte2,
  // base registers
  input  wire [15:0] indexHX,
  input  wire [15:0] stackPtr,
  // result
  output reg  [15:0] effAddr
);
  // one sum per offset mode; offsets unsigned
  always @* begin
    case (mode)
      `CTAD_M_DIR: effAddr = {8'h00, byte1};
      `CTAD_M_EXT: effAddr = {byte1, byte2};
      `CTAD_M_IXP: effAddr = indexHX;
      `CTAD_M_IX:  effAddr = indexHX;
      `CTAD_M_IX1: effAddr = indexHX + {8'h00, byte1};
      `CTAD_M_IX1P: effAddr = indexHX + {8'h00, byte1};
      `CTAD_M_IX2: effAddr = indexHX + {byte1, byte2};
      `CTAD_M_SP1: effAddr = stackPtr + {8'h00, byte1};
      `CTAD_M_SP2: effAddr = stackPtr + {byte1, byte2};
      default:     effAddr = 16'h0000;
    endcase
  end
endmodule // ctad_agen

// file: src/ctad_axil.v
// axi4-lite slave front end for the core registers
`timescale 1ns/1ps
module ctad_axil (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // write address and data
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // read
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // register side
  output wire        wrEn,
  output reg  [7:0]  wrAddr,
  output reg  [31:0] wrData,
  output reg  [3:0]  wrStrb,
  input  wire        wrOk,
  output wire [7:0]  rdAddr,
  input  wire [31:0] rdData,
  input  wire        rdOk
);
  reg awHeld_r;
  reg wHeld_r;
  // each channel takes one item while its holder is empty
  assign s_axi_awready = ~awHeld_r;
  assign s_axi_wready  = ~wHeld_r;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wrEn   = awHeld_r & wHeld_r & ~s_axi_bvalid;
  assign rdAddr = s_axi_araddr;
  // capture address and data, answer once both are in
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      wrAddr <= 8'h00;
      wrData <= 32'h0000_0000;
      wrStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid & ~awHeld_r) begin
        awHeld_r <= 1'b1;
        wrAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & ~wHeld_r) begin
        wHeld_r <= 1'b1;
        wrData <= s_axi_wdata;
        wrStrb <= s_axi_wstrb;
      end
      if (wrEn) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrOk ? 2'b00 : 2'b10; // slverr off map
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid & ~s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdOk ? rdData : 32'h0000_0000;
        s_axi_rresp <= rdOk ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // ctad_axil

// file: src/ctad_core.v
// instruction sequencer for test, transfer, move and compare-branch
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "ctad_defines.vh"
module ctad_core (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // register bus
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  // system memory bus
  output reg  [15:0] memAddr,
  output reg  [7:0]  memWdata,
  output reg         memWe,
  output reg         memReq,
  input  wire        memAck,
  input  wire [7:0]  memRdata
);
  // sequencer states
  localparam S_IDLE = 3'd0;
  localparam S_FETCH = 3'd1;
  localparam S_OPND = 3'd2;
  localparam S_EXEC = 3'd3;
  localparam S_RD = 3'd4;
  localparam S_WR = 3'd5;
  localparam S_HOLD = 3'd6;

  reg  [2:0]  state_r;
  reg         run_r;
  reg         illegal_r;
  reg         pre_r;
  reg  [15:0] pc_r;
  reg  [7:0]  acc_r;
  reg  [7:0]  xLow_r;
  reg  [7:0]  xHigh_r;
  reg  [15:0] sp_r;
  reg  [7:0]  ccr_r;
  reg  [3:0]  opMode_r;
  reg  [3:0]  opAct_r;
  reg  [1:0]  opLeft_r;
  reg         byteIdx_r;
  reg  [7:0]  b1_r;
  reg  [7:0]  b2_r;
  reg  [31:0] count_r;
  reg  [3:0]  decMode;
  reg  [3:0]  decAct;
  reg  [1:0]  decCnt;
  reg  [31:0] rdData;
  reg         rdOk;
  wire [15:0] effAddr;
  wire [15:0] hx;
  wire [7:0]  relOff;
  wire        memDone;
  wire        quiet;
  wire        wrEn;
  wire [7:0]  wrAddr;
  wire [31:0] wrData;
  wire [3:0]  wrStrb;
  wire        wrOk;
  wire [7:0]  rdAddr;

  assign hx = {xHigh_r, xLow_r};
  assign memDone = memReq & memAck;
  // PC, A, H:X, SP and CCR only change from the bus while stopped; CTRL and STATUS writes act at any time
  assign quiet = (state_r == S_IDLE) & ~run_r;
  // post-increment forms carry the relative byte last
  assign relOff = (opMode_r == `CTAD_M_IXP) ? b1_r : b2_r;
  assign wrOk = (wrAddr[1:0] == 2'b00) & (wrAddr <= `CTAD_REG_COUNT);

  // flag update for test and store results
  function [7:0] tstFlags;
    input [7:0] c;
    input [7:0] d;
    begin
      tstFlags = c;
      tstFlags[`CTAD_CCR_V] = 1'b0;
      tstFlags[`CTAD_CCR_N] = d[7];
      tstFlags[`CTAD_CCR_Z] = (d == 8'h00);
    end
  endfunction

  // byte lane merge for 16-bit register writes
  function [15:0] merge;
    input [15:0] old;
    input [15:0] nw;
    input [1:0]  strb;
    integer i;
    begin
      for (i = 0; i < 2; i = i + 1) begin
        merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
    end
  endfunction

  // bus slave
  ctad_axil uAxil (
    .clk           (clk),
    .rst           (rst),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wrEn          (wrEn),
    .wrAddr        (wrAddr),
    .wrData        (wrData),
    .wrStrb        (wrStrb),
    .wrOk          (wrOk),
    .rdAddr        (rdAddr),
    .rdData        (rdData),
    .rdOk          (rdOk)
  );

  // operand address former
  ctad_agen uAgen (
    .mode     (opMode_r),
    .byte1    (b1_r),
    .byte2    (b2_r),
    .indexHX  (hx),
    .stackPtr (sp_r),
    .effAddr  (effAddr)
  );

  // read data mux
  always @* begin
    rdOk = 1'b1;
    case (rdAddr)
      `CTAD_REG_CTRL:   rdData = {31'h0000_0000, run_r};
      `CTAD_REG_STATUS: rdData = {30'h0000_0000, illegal_r,
                                  (state_r != S_IDLE)};
      `CTAD_REG_PC:     rdData = {16'h0000, pc_r};
      `CTAD_REG_ACC:    rdData = {24'h00_0000, acc_r};
      `CTAD_REG_HX:     rdData = {16'h0000, hx};
      `CTAD_REG_SP:     rdData = {16'h0000, sp_r};
      `CTAD_REG_CCR:    rdData = {24'h00_0000, ccr_r};
      `CTAD_REG_COUNT:  rdData = count_r;
      default: begin
        rdData = 32'h0000_0000;
        rdOk = 1'b0;
      end
    endcase
  end

  // opcode decode: mode, action and operand byte count
  always @* begin
    decMode = `CTAD_M_INH;
    decAct = `CTAD_A_ILL;
    decCnt = 2'd0;
    if (pre_r) begin
      case (memRdata)
        `CTAD_OP_TST_IX1: begin
          decMode = `CTAD_M_SP1;
          decAct = `CTAD_A_TSTM;
          decCnt = 2'd1;
        end
        `CTAD_OP_STA_IX1: begin
          decMode = `CTAD_M_SP1;
          decAct = `CTAD_A_STA;
          decCnt = 2'd1;
        end
        `CTAD_OP_STA_IX2: begin
          decMode = `CTAD_M_SP2;
          decAct = `CTAD_A_STA;
          decCnt = 2'd2;
        end
        default: decAct = `CTAD_A_ILL;
      endcase
    end else begin
      case (memRdata)
        `CTAD_OP_TST_DIR: begin
          decMode = `CTAD_M_DIR;
          decAct = `CTAD_A_TSTM;
          decCnt = 2'd1;
        end
        `CTAD_OP_TST_A: decAct = `CTAD_A_TSTA;
        `CTAD_OP_TST_X: decAct = `CTAD_A_TSTX;
        `CTAD_OP_TST_IX1: begin
          decMode = `CTAD_M_IX1;
          decAct = `CTAD_A_TSTM;
          decCnt = 2'd1;
        end
        `CTAD_OP_TST_IX: begin
          decMode = `CTAD_M_IX;
          decAct = `CTAD_A_TSTM;
        end
        `CTAD_OP_STA_EXT: begin
          decMode = `CTAD_M_EXT;
          decAct = `CTAD_A_STA;
          decCnt = 2'd2;
        end
        `CTAD_OP_STA_IX2: begin
          decMode = `CTAD_M_IX2;
          decAct = `CTAD_A_STA;
          decCnt = 2'd2;
        end
        `CTAD_OP_STA_IX1: begin
          decMode = `CTAD_M_IX1;
          decAct = `CTAD_A_STA;
          decCnt = 2'd1;
        end
        `CTAD_OP_STA_IX: begin
          decMode = `CTAD_M_IX;
          decAct = `CTAD_A_STA;
        end
        `CTAD_OP_CBQ_DIR: begin
          decMode = `CTAD_M_DIR;
          decAct = `CTAD_A_CBEQ;
          decCnt = 2'd2;
        end
        `CTAD_OP_CBQ_X1P: begin
          decMode = `CTAD_M_IX1P;
          decAct = `CTAD_A_CBEQ;
          decCnt = 2'd2;
        end
        `CTAD_OP_CBQ_XP: begin
          decMode = `CTAD_M_IXP;
          decAct = `CTAD_A_CBEQ;
          decCnt = 2'd1;
        end
        `CTAD_OP_MOV_DXP: begin
          decMode = `CTAD_M_DIR;
          decAct = `CTAD_A_MOVDX;
          decCnt = 2'd1;
        end
        `CTAD_OP_MOV_IMD: begin
          decAct = `CTAD_A_MOVID;
          decCnt = 2'd2;
        end
        `CTAD_OP_TSX: decAct = `CTAD_A_TSX;
        `CTAD_OP_TXS: decAct = `CTAD_A_TXS;
        `CTAD_OP_TXA: decAct = `CTAD_A_TXA;
        default: decAct = `CTAD_A_ILL;
      endcase
    end
  end

  // bus writes and the instruction sequencer
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= S_IDLE;
      run_r <= 1'b0;
      illegal_r <= 1'b0;
      pre_r <= 1'b0;
      pc_r <= 16'h0000;
      acc_r <= 8'h00;
      xLow_r <= 8'h00;
      xHigh_r <= 8'h00;
      sp_r <= `CTAD_RST_SP;
      ccr_r <= `CTAD_RST_CCR;
      opMode_r <= `CTAD_M_INH;
      opAct_r <= `CTAD_A_ILL;
      opLeft_r <= 2'd0;
      byteIdx_r <= 1'b0;
      b1_r <= 8'h00;
      b2_r <= 8'h00;
      count_r <= 32'h0000_0000;
      memAddr <= 16'h0000;
      memWdata <= 8'h00;
      memWe <= 1'b0;
      memReq <= 1'b0;
    end else begin
      if (wrEn && wrOk) begin
        case (wrAddr)
          `CTAD_REG_CTRL: if (wrStrb[0]) run_r <= wrData[0];
          `CTAD_REG_STATUS: if (wrStrb[0] && wrData[1])
            illegal_r <= 1'b0;
          default: if (quiet) begin
            case (wrAddr)
              `CTAD_REG_PC:
                pc_r <= merge(pc_r, wrData[15:0],
                              wrStrb[1:0]);
              `CTAD_REG_ACC: if (wrStrb[0]) acc_r <= wrData[7:0];
              `CTAD_REG_HX: begin
                if (wrStrb[0]) xLow_r <= wrData[7:0];
                if (wrStrb[1]) xHigh_r <= wrData[15:8];
              end
              `CTAD_REG_SP:
                sp_r <= merge(sp_r, wrData[15:0],
                              wrStrb[1:0]);
              `CTAD_REG_CCR: if (wrStrb[0]) ccr_r <= wrData[7:0];
              default: count_r <= count_r;
            endcase
          end
        endcase
      end
      case (state_r)
        S_IDLE: if (run_r) begin
          memAddr <= pc_r;
          memWe <= 1'b0;
          memReq <= 1'b1;
          pre_r <= 1'b0;
          state_r <= S_FETCH;
        end
        S_FETCH: if (memDone) begin
          pc_r <= pc_r + 16'h0001;
          memAddr <= pc_r + 16'h0001;
          if (!pre_r && memRdata == `CTAD_OP_PRE) begin
            pre_r <= 1'b1;
          end else begin
            opMode_r <= decMode;
            opAct_r <= decAct;
            opLeft_r <= decCnt;
            byteIdx_r <= 1'b0;
            count_r <= count_r + 32'h0000_0001;
            if (decCnt == 2'd0) begin
              memReq <= 1'b0;
              state_r <= S_EXEC;
            end else begin
              state_r <= S_OPND;
            end
          end
        end
        // operand bytes arrive in stream order
        S_OPND: if (memDone) begin
          if (byteIdx_r) b2_r <= memRdata;
          else b1_r <= memRdata;
          byteIdx_r <= 1'b1;
          pc_r <= pc_r + 16'h0001;
          memAddr <= pc_r + 16'h0001;
          opLeft_r <= opLeft_r - 2'd1;
          if (opLeft_r == 2'd1) begin
            memReq <= 1'b0;
            state_r <= S_EXEC;
          end
        end
        S_EXEC: begin
          state_r <= S_IDLE;
          case (opAct_r)
            `CTAD_A_TSTA: ccr_r <= tstFlags(ccr_r, acc_r);
            `CTAD_A_TSTX: ccr_r <= tstFlags(ccr_r, xLow_r);
            `CTAD_A_TXA: acc_r <= xLow_r;
            `CTAD_A_TSX: begin
              {xHigh_r, xLow_r} <= sp_r + 16'h0001;
              state_r <= S_HOLD;
            end
            `CTAD_A_TXS: begin
              sp_r <= hx - 16'h0001;
              state_r <= S_HOLD;
            end
            `CTAD_A_TSTM, `CTAD_A_CBEQ, `CTAD_A_MOVDX: begin
              memAddr <= effAddr;
              memWe <= 1'b0;
              memReq <= 1'b1;
              state_r <= S_RD;
            end
            `CTAD_A_STA: begin
              memAddr <= effAddr;
              memWdata <= acc_r;
              memWe <= 1'b1;
              memReq <= 1'b1;
              state_r <= S_WR;
            end
            `CTAD_A_MOVID: begin
              memAddr <= {8'h00, b2_r};
              memWdata <= b1_r;
              memWe <= 1'b1;
              memReq <= 1'b1;
              state_r <= S_WR;
            end
            default: begin
              illegal_r <= 1'b1; // stop on unknown opcode
              run_r <= 1'b0;
            end
          endcase
        end
        // second cycle of the stack transfers
        S_HOLD: state_r <= S_IDLE;
        S_RD: if (memDone) begin
          memReq <= 1'b0;
          state_r <= S_IDLE;
          case (opAct_r)
            `CTAD_A_TSTM: ccr_r <= tstFlags(ccr_r, memRdata);
            `CTAD_A_CBEQ: begin
              if (acc_r == memRdata)
                pc_r <= pc_r + {{8{relOff[7]}}, relOff};
              if (opMode_r == `CTAD_M_IXP ||
                  opMode_r == `CTAD_M_IX1P)
                {xHigh_r, xLow_r} <= hx + 16'h0001;
            end
            default: begin
              memAddr <= hx;
              memWdata <= memRdata;
              memWe <= 1'b1;
              memReq <= 1'b1;
              state_r <= S_WR;
            end
          endcase
        end
        S_WR: if (memDone) begin
          memReq <= 1'b0;
          memWe <= 1'b0;
          ccr_r <= tstFlags(ccr_r, memWdata);
          if (opAct_r == `CTAD_A_MOVDX)
            {xHigh_r, xLow_r} <= hx + 16'h0001;
          state_r <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end
endmodule // ctad_core

// file: test/cpu_test_and_addressing_decode_tb.sv
// bench for the decode core: bus master, memory and checks
`timescale 1ns/1ps
module cpu_test_and_addressing_decode_tb;
  logic        clk = 0, rst = 1, memAck = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, memRdata;
  logic [31:0] s_axi_wdata = 0, d;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire         s_axi_arready, s_axi_rvalid, memWe, memReq;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [15:0] memAddr;
  wire  [7:0]  memWdata;
  logic [7:0]  mem [0:65535];
  logic [34:0] q [$];
  logic [34:0] e;
  logic [39:0] pw;
  logic        fa, fw, fb, fr;
  int          i, k, seed = 40306, fail_count = 0, checks_done = 0;

  ctad_core i_dut (.*);

  always #50 clk = ~clk;

  // memory with random stalls; released data bus shows a changing pattern
  always @(posedge clk) begin
    memAck <= $random(seed);
    if (memReq && memAck && memWe) mem[memAddr] <= memWdata;
  end
  always @* memRdata = (memReq && !memWe) ? mem[memAddr] : ~memAddr[7:0];

  // read monitor takes the oldest note
  always @(posedge clk) if (s_axi_rvalid && s_axi_rready) begin
    e = q.pop_front();
    if (e[34]) chk({s_axi_rresp, s_axi_rdata}, e[33:0]);
  end

  task chk(input [33:0] got, input [33:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task conclude;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // one register write, address and data offered together
  task wr(input [7:0] a, input [31:0] v);
    s_axi_awaddr <= a; s_axi_wdata <= v;
    s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    fb = 0;
    for (i = 0; i < 50 && !fb; i++) begin
      @(negedge clk);
      fa = s_axi_awvalid && s_axi_awready;
      fw = s_axi_wvalid && s_axi_wready;
      fb = s_axi_bvalid;
      @(posedge clk);
      if (fa) s_axi_awvalid <= 0;
      if (fw) s_axi_wvalid <= 0;
    end
    s_axi_bready <= 0;
    if (!fb) begin fail_count++; conclude; end
    @(posedge clk);
  endtask

  // one register read; the note goes on the queue
  task rd(input [7:0] a, input [34:0] n, output [31:0] v);
    q.push_back(n);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    fr = 0;
    for (i = 0; i < 50 && !fr; i++) begin
      @(negedge clk);
      fa = s_axi_arvalid && s_axi_arready;
      fr = s_axi_rvalid;
      v = s_axi_rdata;
      @(posedge clk);
      if (fa) s_axi_arvalid <= 0;
    end
    s_axi_rready <= 0;
    if (!fr) begin fail_count++; conclude; end
    @(posedge clk);
  endtask

  task ck(input [7:0] a, input [31:0] v);
    rd(a, {3'b100, v}, d);
  endtask

  task mk(input [15:0] a, input [7:0] v);
    chk({26'd0, mem[a]}, {26'd0, v});
  endtask

  // load program at 0x0100, stop byte after it, run until halted
  task exe(input [31:0] p, hx, sp, a, c);
    pw = {p, 8'h00};
    // left-justify so the opcode is the first byte, a zero byte stops
    for (k = 0; k < 3 && pw[39:32] == 8'h00; k++) pw = pw << 8;
    for (k = 0; k < 5; k++) mem[16'h0100 + k] = pw[39-8*k -: 8];
    wr(8'h0C, a); wr(8'h10, hx); wr(8'h14, sp); wr(8'h18, c);
    wr(8'h08, 32'h0000_0100); wr(8'h04, 32'h0000_0002);
    wr(8'h00, 32'h0000_0001);
    d = 1;
    for (k = 0; k < 300 && d[0]; k++) rd(8'h00, 35'd0, d);
    if (d[0]) begin fail_count++; conclude; end
  endtask

  initial begin
    for (k = 0; k < 65536; k++) mem[k] = k[7:0] ^ 8'hA5;
    repeat (8) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    ck(8'h14, 32'h0000_00FF);
    ck(8'h18, 32'h0000_0068);
    rd(8'h40, {3'b110, 32'h0000_0000}, d);
    // test on A, X and memory in each mode
    exe(32'h4D, 0, 16'hFF, 8'h00, 8'hFF); ck(8'h18, 8'h7B);
    exe(32'h5D, 16'h80, 16'hFF, 1, 8'h60); ck(8'h18, 8'h64);
    ck(8'h0C, 1);
    mem[16'h00F5] = 0;
    exe(32'h9E6D05, 0, 16'hF0, 1, 8'hFF); ck(8'h18, 8'h7B);
    mem[16'h1333] = 8'h80;
    exe(32'h6DFF, 16'h1234, 16'hFF, 1, 8'h60); ck(8'h18, 8'h64);
    mem[16'h0040] = 0;
    exe(32'h3D40, 0, 16'hFF, 1, 8'hE0); ck(8'h18, 8'h62);
    mem[16'h2000] = 8'h80;
    exe(32'h7D, 16'h2000, 16'hFF, 1, 8'h60); ck(8'h18, 8'h64);
    // stores through extended, offset16 and stack offset16
    exe(32'hC734_56, 0, 16'hFF, 8'h5A, 8'hE0); mk(16'h3456, 8'h5A);
    ck(8'h18, 8'h60);
    exe(32'hD702_34, 16'h1000, 16'hFF, 8'h81, 8'h60); mk(16'h1234, 8'h81);
    exe(32'h9ED7_0101, 0, 16'hFF, 8'h3C, 8'h60); mk(16'h0200, 8'h3C);
    // moves
    mem[16'h0050] = 8'h77;
    exe(32'h5E50, 16'h3000, 16'hFF, 1, 8'h60); mk(16'h3000, 8'h77);
    ck(8'h10, 16'h3001);
    exe(32'h6E99_60, 0, 16'hFF, 1, 8'h60); mk(16'h0060, 8'h99);
    // compare and branch over a transfer
    mem[16'h4000] = 8'h33;
    exe(32'h7102_9F, 16'h4000, 16'hFF, 8'h33, 8'h60); ck(8'h0C, 8'h33);
    ck(8'h10, 16'h4001);
    mem[16'h4010] = 8'h33;
    exe(32'h6110_029F, 16'h4000, 16'hFF, 8'h33, 8'h60);
    ck(8'h0C, 8'h33); ck(8'h10, 16'h4001);
    mem[16'h0070] = 8'h45;
    exe(32'h3170_029F, 16'h0011, 16'hFF, 8'h44, 8'h60); ck(8'h0C, 8'h11);
    // transfers leave the flags alone
    exe(32'h9495_9F, 16'h0355, 16'hFF, 1, 8'hFF); ck(8'h14, 16'h0354);
    ck(8'h10, 16'h0355); ck(8'h0C, 8'h55);
    ck(8'h18, 8'hFF);
    repeat (4) @(posedge clk);
    conclude;
  end
endmodule // cpu_test_and_addressing_decode_tb

// file: test/ctad_core_assertions.sv
// port assertions for the decode core
`timescale 1ns/1ps
module ctad_core_chk (
  // clock and reset
  input wire        clk,
  input wire        rst,
  // register bus
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // memory bus
  input wire [15:0] memAddr,
  input wire [7:0]  memWdata,
  input wire        memWe,
  input wire        memReq,
  input wire        memAck
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  // memory access held until taken
  a_mem_hold: assert property (
    memReq && !memAck |=> memReq && $stable({memAddr, memWe, memWdata}))
    else $error("memory request changed before ack");
  a_we_req: assert property (
    memWe |-> memReq)
    else $error("write strobe without request");
  // read answer and hold
  a_ar_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_r_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable({s_axi_rdata, s_axi_rresp}))
    else $error("read answer changed before taken");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'b10
    |-> s_axi_rdata == 32'h0000_0000)
    else $error("error read returns data");
  // write answer timing and hold
  a_b_timing: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer changed before taken");
  a_resp_code: assert property (s_axi_bvalid |->
    s_axi_bresp == 2'b00 || s_axi_bresp == 2'b10)
    else $error("write answer code unknown");
  // main scenarios
  c_mem_wr: cover property (memReq && memAck && memWe);
  c_rd_err: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
  c_wr_done: cover property (s_axi_bvalid && s_axi_bready);
endmodule // ctad_core_chk
bind ctad_core ctad_core_chk i_chk (.clk, .rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .memAddr, .memWdata, .memWe, .memReq, .memAck);
